// >>> rtl/calendar_schedule_timers.sv
// four calendar timers with an axi4-lite register slave
// Summary of operation
// (R1) Four independent timers exist, each with its own settings and output.
// (R2) Each timer holds an activation and a deactivation time as hh:mm:ss.
// (R3) Each timer has a mode register choosing one of twelve schedules.
// (R4) In the not-in-use mode the timer does not run and its output stays 0.
// (R5) In daily mode the output switches on and off once every day.
// (R6) Seven single-day modes switch only on their own weekday.
// (R7) Working-week mode switches Monday to Friday and idles at weekends.
// (R8) Monday-to-Saturday mode switches on every day but Sunday.
// (R9) Weekend mode switches only on Saturday and Sunday.
// (R10) Software forces a timer in use by writing its state, 0 off, 1 on.
// (R11) A state write takes effect at once, with no separate force flag.
// (R12) A forced state holds until the next write or scheduled reversal.
// (R13) Timer states are saved at power loss and restored at startup.
// (R14) The timer outputs feed the logic, blocking and output matrix.
// (R15) On a qualifying day the output sets at the on time, clears at off.
`timescale 1ns/10ps
module calendar_schedule_timers (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire calendar_timers_pkg::tod_t rtc_time_i,
    input wire logic [2:0] rtc_day_i,
    input wire logic rtc_sec_tick_i,
    input wire logic power_fail_i,
    output logic nv_save_o,
    output logic [3:0] nv_save_data_o,
    input wire logic nv_restore_i,
    input wire logic [3:0] nv_restore_data_i,
    output logic [3:0] schedule_output_state_o
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // address inside the map; low bits ignored, the word is what counts
    function automatic logic map_hit(input logic [7:0] a);
        return a < calendar_timers_pkg::MAP_END;
    endfunction

    function automatic logic [31:0] tod_word(
        input calendar_timers_pkg::tod_t t);
        logic [31:0] w;
        w = 32'h0;
        w[calendar_timers_pkg::HOUR_LSB +: 5] = t.hour;
        w[calendar_timers_pkg::MIN_LSB +: 6] = t.minute;
        w[calendar_timers_pkg::SEC_LSB +: 6] = t.second;
        return w;
    endfunction

    function automatic calendar_timers_pkg::tod_t word_tod(
        input logic [31:0] w);
        calendar_timers_pkg::tod_t t;
        t.hour = w[calendar_timers_pkg::HOUR_LSB +: 5];
        t.minute = w[calendar_timers_pkg::MIN_LSB +: 6];
        t.second = w[calendar_timers_pkg::SEC_LSB +: 6];
        return t;
    endfunction

    // byte-lane merge of a write into the old word
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // does this mode switch on the given weekday
    function automatic logic day_match(input logic [3:0] m,
        input logic [2:0] d);
        logic r;
        case (m)
            calendar_timers_pkg::MODE_DAILY: r = 1'b1; // R5
            calendar_timers_pkg::MODE_WORKING_WEEK:
                r = d <= calendar_timers_pkg::DAY_FRIDAY; // R7
            calendar_timers_pkg::MODE_MON_TO_SAT:
                r = d != calendar_timers_pkg::DAY_SUNDAY; // R8
            calendar_timers_pkg::MODE_WEEKEND:
                r = d >= calendar_timers_pkg::DAY_SATURDAY &&
                    d <= calendar_timers_pkg::DAY_SUNDAY; // R9
            default:
                // single-day modes; unused and unknown codes never match
                r = m >= calendar_timers_pkg::MODE_MONDAY &&
                    m <= calendar_timers_pkg::MODE_SUNDAY &&
                    {1'b0, d} == 4'(m - calendar_timers_pkg::MODE_MONDAY); // R6
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    calendar_timers_pkg::block_state_t st_ff;
    calendar_timers_pkg::block_state_t nxt_st;

    logic wr_fire;
    logic [1:0] wr_idx;
    logic [1:0] wr_sel;
    logic [31:0] wr_word;

    // a write commits once both address and data are held
    assign wr_fire = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
    assign wr_idx = st_ff.awaddr[5:4];
    assign wr_sel = st_ff.awaddr[3:2];

    // handshake readies straight from the holding flags
    assign s_axi_awready_o = !st_ff.aw_held && !st_ff.bvalid;
    assign s_axi_wready_o = !st_ff.w_held && !st_ff.bvalid;
    assign s_axi_arready_o = !st_ff.rvalid;
    assign s_axi_bvalid_o = st_ff.bvalid;
    assign s_axi_bresp_o = st_ff.bresp;
    assign s_axi_rvalid_o = st_ff.rvalid;
    assign s_axi_rdata_o = st_ff.rdata;
    assign s_axi_rresp_o = st_ff.rresp;
    assign nv_save_o = st_ff.nv_save;
    assign nv_save_data_o = st_ff.nv_data;

    // one output per timer, straight from its state flop
    generate
        for (genvar g = 0; g < calendar_timers_pkg::NUM_TIMERS; g++) begin : g_out
            assign schedule_output_state_o[g] = st_ff.tmr[g].active; // R14 R1
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    // scheduled switching, then software writes, then nv restore
    always_comb begin
        logic [31:0] cur;
        logic [1:0] ri;
        nxt_st = st_ff;
        wr_word = 32'h0;
        cur = 32'h0;
        ri = s_axi_araddr_i[5:4];
        nxt_st.nv_save = 1'b0;
        nxt_st.pfail_q = power_fail_i;

        // schedule: compare once per second against the clock
        for (int i = 0; i < calendar_timers_pkg::NUM_TIMERS; i++) begin
            if (rtc_sec_tick_i &&
                day_match(st_ff.tmr[i].mode, rtc_day_i)) begin // R6 R7 R8 R9
                // activation wins if both times are programmed equal
                if (rtc_time_i == st_ff.tmr[i].on_time) begin
                    nxt_st.tmr[i].active = 1'b1; // R15 R5 R12
                end else if (rtc_time_i == st_ff.tmr[i].off_time) begin
                    nxt_st.tmr[i].active = 1'b0; // R15 R5 R12
                end
            end
        end

        // write channel capture, either order
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            nxt_st.aw_held = 1'b1;
            nxt_st.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            nxt_st.w_held = 1'b1;
            nxt_st.wdata = s_axi_wdata_i;
            nxt_st.wstrb = s_axi_wstrb_i;
        end

        // register write; the later software write beats the schedule
        if (wr_fire) begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = calendar_timers_pkg::RESP_SLVERR;
            if (map_hit(st_ff.awaddr)) begin
                nxt_st.bresp = calendar_timers_pkg::RESP_OKAY;
                case (wr_sel)
                    calendar_timers_pkg::SEL_ON: begin
                        wr_word = merge(tod_word(st_ff.tmr[wr_idx].on_time),
                            st_ff.wdata, st_ff.wstrb);
                        nxt_st.tmr[wr_idx].on_time = word_tod(wr_word); // R2
                    end
                    calendar_timers_pkg::SEL_OFF: begin
                        wr_word = merge(tod_word(st_ff.tmr[wr_idx].off_time),
                            st_ff.wdata, st_ff.wstrb);
                        nxt_st.tmr[wr_idx].off_time = word_tod(wr_word); // R2
                    end
                    calendar_timers_pkg::SEL_MODE: begin
                        if (st_ff.wstrb[0]) begin
                            nxt_st.tmr[wr_idx].mode = st_ff.wdata[3:0]; // R3
                            // leaving service drops the output at once
                            if (st_ff.wdata[3:0] ==
                                calendar_timers_pkg::MODE_UNUSED) begin
                                nxt_st.tmr[wr_idx].active = 1'b0; // R4
                            end
                        end
                    end
                    default: begin
                        // direct force, no enable flag; unused timers ignore it
                        if (st_ff.wstrb[0] && st_ff.tmr[wr_idx].mode !=
                            calendar_timers_pkg::MODE_UNUSED) begin
                            nxt_st.tmr[wr_idx].active = st_ff.wdata[0]; // R10 R11
                        end
                    end
                endcase
            end
        end
        if (st_ff.bvalid && s_axi_bready_i) begin
            nxt_st.bvalid = 1'b0;
        end

        // read: answer one cycle after the address is taken
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            case (s_axi_araddr_i[3:2])
                calendar_timers_pkg::SEL_ON:
                    cur = tod_word(st_ff.tmr[ri].on_time);
                calendar_timers_pkg::SEL_OFF:
                    cur = tod_word(st_ff.tmr[ri].off_time);
                calendar_timers_pkg::SEL_MODE:
                    cur = {28'h0, st_ff.tmr[ri].mode};
                default:
                    cur = {31'h0, st_ff.tmr[ri].active}; // R10
            endcase
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = map_hit(s_axi_araddr_i) ? cur : 32'h0;
            nxt_st.rresp = map_hit(s_axi_araddr_i) ?
                calendar_timers_pkg::RESP_OKAY :
                calendar_timers_pkg::RESP_SLVERR;
        end else if (st_ff.rvalid && s_axi_rready_i) begin
            nxt_st.rvalid = 1'b0;
        end

        // restore at startup; only timers in use take a set state
        if (nv_restore_i) begin
            for (int i = 0; i < calendar_timers_pkg::NUM_TIMERS; i++) begin
                nxt_st.tmr[i].active = nv_restore_data_i[i] &&
                    nxt_st.tmr[i].mode !=
                    calendar_timers_pkg::MODE_UNUSED; // R13 R4
            end
        end

        // snapshot the states on the rising edge of power failure
        if (power_fail_i && !st_ff.pfail_q) begin
            nxt_st.nv_save = 1'b1; // R13
            for (int i = 0; i < calendar_timers_pkg::NUM_TIMERS; i++) begin
                nxt_st.nv_data[i] = st_ff.tmr[i].active; // R13
            end
        end
    end

    // single state register
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff <= '0;
            for (int i = 0; i < calendar_timers_pkg::NUM_TIMERS; i++) begin
                st_ff.tmr[i].mode <= calendar_timers_pkg::MODE_RST;
                st_ff.tmr[i].active <= calendar_timers_pkg::STATE_RST;
            end
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic quiet;
    assign quiet = !rtc_sec_tick_i && !wr_fire && !nv_restore_i;

    unused_low_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        st_ff.tmr[0].mode == calendar_timers_pkg::MODE_UNUSED
        |-> !schedule_output_state_o[0]) // R4
        else $error("unused timer output not low");

    sched_on_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        rtc_sec_tick_i && !wr_fire && !nv_restore_i &&
        day_match(st_ff.tmr[1].mode, rtc_day_i) &&
        rtc_time_i == st_ff.tmr[1].on_time
        |=> schedule_output_state_o[1]) // R15
        else $error("timer missed its activation time");

    sched_off_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        rtc_sec_tick_i && !wr_fire && !nv_restore_i &&
        day_match(st_ff.tmr[1].mode, rtc_day_i) &&
        rtc_time_i == st_ff.tmr[1].off_time &&
        rtc_time_i != st_ff.tmr[1].on_time
        |=> !schedule_output_state_o[1]) // R15
        else $error("timer missed its deactivation time");

    force_write_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        wr_fire && wr_sel == calendar_timers_pkg::SEL_STATE &&
        map_hit(st_ff.awaddr) && st_ff.wstrb[0] && !nv_restore_i &&
        st_ff.tmr[wr_idx].mode != calendar_timers_pkg::MODE_UNUSED
        |=> st_ff.tmr[$past(wr_idx)].active == $past(st_ff.wdata[0])) // R11
        else $error("state write did not force the output");

    force_hold_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        quiet [*2] |=> $stable(schedule_output_state_o)) // R12
        else $error("timer output moved with no cause");

    weekend_idle_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        !wr_fire && !nv_restore_i && rtc_day_i >=
        calendar_timers_pkg::DAY_SATURDAY &&
        st_ff.tmr[1].mode == calendar_timers_pkg::MODE_WORKING_WEEK
        |=> $stable(schedule_output_state_o[1])) // R7
        else $error("working-week timer switched at the weekend");

    nv_save_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        $rose(power_fail_i) ##1 1'b1
        |-> nv_save_o && nv_save_data_o ==
        $past(schedule_output_state_o) ##1 !nv_save_o) // R13
        else $error("power-fail snapshot wrong");

    nv_restore_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        nv_restore_i && !wr_fire &&
        st_ff.tmr[2].mode != calendar_timers_pkg::MODE_UNUSED
        |=> schedule_output_state_o[2] == $past(nv_restore_data_i[2])) // R13
        else $error("restored state not applied");

    bvalid_hold_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("write response dropped early");

endmodule // calendar_schedule_timers

// >>> rtl/calendar_timers_pkg.sv
// constants and types shared by the calendar schedule timer block
package calendar_timers_pkg;
    // number of independent timers
    localparam int NUM_TIMERS = 4;
    // register layout: each timer owns a 16-byte slot of four words
    localparam logic [7:0] TIMER_SPAN = 8'h10;
    localparam logic [7:0] MAP_END = 8'h40;
    localparam logic [1:0] SEL_ON = 2'h0;
    localparam logic [1:0] SEL_OFF = 2'h1;
    localparam logic [1:0] SEL_MODE = 2'h2;
    localparam logic [1:0] SEL_STATE = 2'h3;
    // time-of-day field positions inside a register word
    localparam int HOUR_LSB = 16;
    localparam int MIN_LSB = 8;
    localparam int SEC_LSB = 0;
    // schedule mode codes
    localparam logic [3:0] MODE_UNUSED = 4'h0;
    localparam logic [3:0] MODE_DAILY = 4'h1;
    localparam logic [3:0] MODE_MONDAY = 4'h2;
    localparam logic [3:0] MODE_SUNDAY = 4'h8;
    localparam logic [3:0] MODE_WORKING_WEEK = 4'h9;
    localparam logic [3:0] MODE_MON_TO_SAT = 4'ha;
    localparam logic [3:0] MODE_WEEKEND = 4'hb;
    // day-of-week codes, monday first
    localparam logic [2:0] DAY_FRIDAY = 3'h4;
    localparam logic [2:0] DAY_SATURDAY = 3'h5;
    localparam logic [2:0] DAY_SUNDAY = 3'h6;
    // reset values
    localparam logic [3:0] MODE_RST = 4'h0;
    localparam logic STATE_RST = 1'b0;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
    } tod_t;

    typedef struct packed {
        tod_t on_time;
        tod_t off_time;
        logic [3:0] mode;
        logic active;
    } timer_t;

    typedef struct packed {
        timer_t [NUM_TIMERS-1:0] tmr;
        logic aw_held;
        logic [7:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic pfail_q;
        logic nv_save;
        logic [NUM_TIMERS-1:0] nv_data;
    } block_state_t;
endpackage

// >>> tb/nv_store_model.sv
// non-volatile store standing in for the far side across power loss
`timescale 1ns/10ps
module nv_store_model (
    input wire logic clk_i,
    input wire logic save_i,
    input wire logic [3:0] save_data_i,
    input wire logic restore_req_i,
    output logic restore_o,
    output logic [3:0] restore_data_o
);
    logic [3:0] mem_ff;
    ////////////////////////////////////////////////////////////////////
    // no reset here: contents must outlive the device reset
    initial begin
        mem_ff = 4'h0;
        restore_o = 1'b0;
        restore_data_o = 4'hf;
    end
    // capture on the save pulse, replay on request
    always @(posedge clk_i) begin
        if (save_i) begin
            mem_ff <= save_data_i;
        end
        restore_o <= restore_req_i;
        // outside the strobe the data lines carry junk, not the last value
        restore_data_o <= restore_req_i ? mem_ff : ~mem_ff;
    end
endmodule // nv_store_model

// >>> tb/calendar_schedule_timers_tb.sv
// self-checking bench for the calendar schedule timers
`timescale 1ns/10ps
module calendar_schedule_timers_tb;
    localparam logic [1:0] OK = calendar_timers_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = calendar_timers_pkg::RESP_SLVERR;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic tick, pfail, nv_save, nv_rest, rest_req;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, nv_sdata, nv_rdata, outs;
    logic [1:0] bresp, rresp;
    logic [2:0] rtc_day;
    calendar_timers_pkg::tod_t rtc_time;
    int failures, num_checks, cycles, seed;
    int on_w[4], off_w[4], mode_m[4], st[4];
    ////////////////////////////////////////////////////////////////////
    calendar_schedule_timers i_calendar_schedule_timers (
        .ref_clk_i(clk), .reset_n_i(rst_n),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .rtc_time_i(rtc_time),
        .rtc_day_i(rtc_day), .rtc_sec_tick_i(tick),
        .power_fail_i(pfail), .nv_save_o(nv_save),
        .nv_save_data_o(nv_sdata), .nv_restore_i(nv_rest),
        .nv_restore_data_i(nv_rdata), .schedule_output_state_o(outs)
    );
    nv_store_model i_nv_store_model (
        .clk_i(clk), .save_i(nv_save), .save_data_i(nv_sdata),
        .restore_req_i(rest_req), .restore_o(nv_rest),
        .restore_data_o(nv_rdata)
    );
    ////////////////////////////////////////////////////////////////////
    // clock and cycle ceiling; the ceiling is over twenty times the run
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    function automatic logic [3:0] stv();
        logic [3:0] e;
        for (int n = 0; n < 4; n++) e[n] = st[n][0];
        return e;
    endfunction
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: word %h not %h", $time, got, exp);
        end
    endtask
    // outputs compared at the falling edge, well away from updates
    task automatic chk();
        @(negedge clk);
        num_checks++;
        if (outs !== stv()) begin
            failures++;
            $display("wrong value at %0t: outputs %b not %b", $time, outs,
                stv());
        end
        @(posedge clk);
    endtask
    // ready is sampled midway; it only moves at rising edges
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        logic aw, w, ag, wg;
        logic [1:0] r;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw || w) begin
            @(negedge clk);
            ag = aw && awready === 1'b1;
            wg = w && wready === 1'b1;
            @(posedge clk);
            if (ag) aw = 1'b0;
            if (ag) awvalid <= 1'b0;
            if (wg) w = 1'b0;
            if (wg) wvalid <= 1'b0;
        end
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ag = bvalid === 1'b1;
            r = bresp;
            @(posedge clk);
        end while (!ag);
        bready <= 1'b0;
        cmp_word({30'h0, r}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        logic g;
        logic [31:0] d;
        logic [1:0] r;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge clk);
            g = arready === 1'b1;
            @(posedge clk);
        end while (!g);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            g = rvalid === 1'b1;
            d = rdata;
            r = rresp;
            @(posedge clk);
        end while (!g);
        rready <= 1'b0;
        cmp_word(d, ed);
        cmp_word({30'h0, r}, {30'h0, er});
    endtask
    ////////////////////////////////////////////////////////////////////
    // register write plus the reference model's view of it
    task automatic setr(input int n, input int s, input logic [31:0] d);
        wr(8'(n * 16 + s * 4), d, OK);
        if (s == 0) on_w[n] = d;
        if (s == 1) off_w[n] = d;
        if (s == 2) mode_m[n] = d[3:0];
        if (s == 2 && d[3:0] == 4'h0) st[n] = 0;
        if (s == 3 && mode_m[n] != 0) st[n] = d[0];
    endtask
    function automatic bit qual(input int m, input int d);
        return m == 1 || (m >= 2 && m <= 8 && d == m - 2) ||
            (m == 9 && d < 5) || (m == 10 && d != 6) ||
            (m == 11 && d >= 5);
    endfunction
    function automatic logic [31:0] rt();
        int h, m, s;
        h = $unsigned($random(seed)) % 24;
        m = $unsigned($random(seed)) % 60;
        s = $unsigned($random(seed)) % 60;
        return (h << 16) | (m << 8) | s;
    endfunction
    // one-cycle tick; output moves one cycle later
    task automatic tk(input logic [31:0] t, input int d);
        rtc_time <= {t[20:16], t[13:8], t[5:0]};
        rtc_day <= 3'(d);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        for (int n = 0; n < 4; n++) begin
            if (mode_m[n] != 0 && qual(mode_m[n], d)) begin
                if (t == on_w[n]) st[n] = 1;
                else if (t == off_w[n]) st[n] = 0;
            end
        end
        chk();
    endtask
    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int n, hits;
        logic [31:0] a, b;
        logic [3:0] sv;
        seed = 16;
        {awvalid, wvalid, bready, arvalid, rready, tick, pfail} = 7'h0;
        {awaddr, araddr, wdata, wstrb, rtc_day, rest_req} = 0;
        rtc_time = '0;
        failures = 0;
        num_checks = 0;
        cycles = 0;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk();
        rd(8'h28, 32'h0, OK);
        rd(8'h24, 32'h0, OK);
        // every mode code on every day, timers in rotation
        for (int m = 0; m <= 12; m++) begin
            n = m % 4;
            a = rt();
            b = rt();
            if (a == b) b = b ^ 32'h1;
            setr(n, 0, a);
            setr(n, 1, b);
            setr(n, 2, m);
            rd(8'(n * 16), a, OK);
            rd(8'(n * 16 + 8), m, OK);
            for (int d = 0; d < 7; d++) begin
                tk(a, d);
                tk(rt(), d);
                tk(b, d);
            end
        end
        // forcing holds until a reversing act or another write
        setr(1, 3, 1);
        chk();
        rd(8'h1c, 32'h1, OK);
        tk(rt(), 0);
        tk(off_w[1], 2);
        setr(0, 3, 1);
        setr(0, 2, 0);
        setr(0, 3, 1);
        chk();
        wr(8'h40, 32'h1, ERR);
        rd(8'hfc, 32'h0, ERR);
        // save at power loss, then restore after a fresh reset
        setr(2, 3, 1);
        setr(3, 3, 1);
        sv = stv();
        hits = 0;
        pfail <= 1'b1;
        repeat (6) begin
            @(negedge clk);
            if (nv_save === 1'b1) hits++;
            if (nv_save === 1'b1) cmp_word(32'(nv_sdata), 32'(sv));
            @(posedge clk);
        end
        cmp_word(32'(hits), 32'h1);
        pfail <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) {mode_m[i], st[i]} = 0;
        chk();
        for (int i = 0; i < 3; i++) setr(i, 2, 1);
        rest_req <= 1'b1;
        @(posedge clk);
        rest_req <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 3; i++) st[i] = sv[i];
        chk();
        wrap_up();
    end
endmodule // calendar_schedule_timers_tb
